/* File: core/tmr_timer_top.v */
// Eight-bit timer control, reload hold registers and AXI4-Lite slave.
`timescale 1ns/100ps
module tmr_timer_top (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_smr,
   input wire i_long_start,
   input wire i_capture_event,
   input wire i_port_data,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg o_eight_bit_timer_output,
   output reg o_port3_pin4,
   output reg o_timeout_irq,
   output reg o_capture_irq,
   output reg o_long_load,
   output reg [15:0] o_long_reload
);
`include "tmr_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Registers.
reg [7:0] ctrl_r;
reg [7:0] short_low_count_r;
reg [7:0] short_high_count_r;
reg [7:0] long_reload_lower_r;
reg [7:0] long_reload_upper_r;
// Down counter state of the eight-bit timer.
reg [7:0] count_r;
reg loaded_r;
reg tc_r;
reg smr_s1_r;
reg smr_s2_r;
reg cap_s1_r;
reg cap_s2_r;
reg cap_d_r;
reg start_s1_r;
reg start_s2_r;
reg start_d_r;
reg port_s1_r;
reg port_s2_r;
// Write address index and data, held until both halves are in.
reg [7:0] aw_idx_r;
reg aw_have_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg w_have_r;
wire tick;
wire wr_go;
wire wr_ctrl;
wire tc_now;
wire [7:0] reload_val;

////////////////////////////////////////////////////////////////////////////
// Each pin passes two flip-flops before any logic looks at it; the third
// stage of the capture and start paths keeps the previous level so that
// only a rising edge produces a pulse.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      smr_s1_r <= 1'b0;
      smr_s2_r <= 1'b0;
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_d_r <= 1'b0;
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      start_d_r <= 1'b0;
      port_s1_r <= 1'b0;
      port_s2_r <= 1'b0;
   end else begin
      smr_s1_r <= i_smr;
      smr_s2_r <= smr_s1_r;
      cap_s1_r <= i_capture_event;
      cap_s2_r <= cap_s1_r;
      cap_d_r <= cap_s2_r;
      start_s1_r <= i_long_start;
      start_s2_r <= start_s1_r;
      start_d_r <= start_s2_r;
      port_s1_r <= i_port_data;
      port_s2_r <= port_s1_r;
   end
end

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path: address and data taken in either order.
// A write completes only once both halves are held and no answer is
// waiting, so a second write cannot overrun an unacknowledged response.
assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
assign wr_ctrl = wr_go && (aw_idx_r == `TMR_IDX_CTRL) && wstrb_r[0];

// Write channel acceptance and response.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TMR_RESP_OK;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= `TMR_RST_BYTE;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
   end else begin
      // Readies stay low from each hand-over until the write completes, and while
      // a response is still waiting for its acknowledge.
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_idx_r <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         s_axi_bvalid <= 1'b1;
         // Index gaps between the control and the hold registers answer
         // with an error and leave every register untouched.
         s_axi_bresp <= (aw_idx_r <= `TMR_IDX_OUTS &&
            (aw_idx_r == `TMR_IDX_CTRL || aw_idx_r >= `TMR_IDX_T8LO)) ?
            `TMR_RESP_OK : `TMR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Hold registers and control fields.
// hold survive recovery
// Only an ordinary reset clears them; stop-mode recovery is ignored here.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      short_low_count_r <= `TMR_RST_BYTE;
      short_high_count_r <= `TMR_RST_BYTE;
      long_reload_lower_r <= `TMR_RST_BYTE;
      long_reload_upper_r <= `TMR_RST_BYTE;
   end else if (wr_go && wstrb_r[0]) begin
      if (aw_idx_r == `TMR_IDX_T8LO)
         short_low_count_r <= wdata_r[7:0];
      if (aw_idx_r == `TMR_IDX_T8HI)
         short_high_count_r <= wdata_r[7:0];
      if (aw_idx_r == `TMR_IDX_T16LO)
         long_reload_lower_r <= wdata_r[7:0];
      if (aw_idx_r == `TMR_IDX_T16HI)
         long_reload_upper_r <= wdata_r[7:0];
   end
end

// Control register; recovery clears run, mode and route but not others.
// Time-out is cleared only by writing one to it, so a read-modify-write
// that returns a set flag would wipe it; the flag itself is never touched
// by stop-mode recovery.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      ctrl_r <= `TMR_RST_BYTE;
   end else begin
      if (smr_s2_r) begin
         ctrl_r[`TMR_RUN_BIT] <= 1'b0;
         ctrl_r[`TMR_ONESHOT_BIT] <= 1'b0;
         ctrl_r[`TMR_ROUTE_BIT] <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_r[`TMR_RUN_BIT] <= wdata_r[`TMR_RUN_BIT];
         ctrl_r[`TMR_ONESHOT_BIT] <= wdata_r[`TMR_ONESHOT_BIT];
         ctrl_r[`TMR_PRE_HI:`TMR_PRE_LO] <= wdata_r[`TMR_PRE_HI:`TMR_PRE_LO];
         ctrl_r[`TMR_CAPMSK_BIT] <= wdata_r[`TMR_CAPMSK_BIT];
         ctrl_r[`TMR_TOMSK_BIT] <= wdata_r[`TMR_TOMSK_BIT];
         ctrl_r[`TMR_ROUTE_BIT] <= wdata_r[`TMR_ROUTE_BIT];
      end
      if (tc_now && ctrl_r[`TMR_ONESHOT_BIT] && !wr_ctrl)
         ctrl_r[`TMR_RUN_BIT] <= 1'b0;
      // write one clears
      // A terminal count in the clearing cycle wins over the clear.
      if (tc_now)
         ctrl_r[`TMR_TOUT_BIT] <= 1'b1;
      else if (wr_ctrl && wdata_r[`TMR_TOUT_BIT])
         ctrl_r[`TMR_TOUT_BIT] <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////
// Eight-bit down counter.
// The prescaler restarts whenever the run bit drops, so each start
// begins with a full divide period.
tmr_prescaler u_pre (
   .i_clock(i_clock),
   .i_sys_rst(i_sys_rst),
   .i_run(ctrl_r[`TMR_RUN_BIT]),
   .i_sel(ctrl_r[`TMR_PRE_HI:`TMR_PRE_LO]),
   .o_tick(tick)
);

// load per level
// The next phase uses the hold for the level the output is about to take.
assign reload_val = o_eight_bit_timer_output ? short_low_count_r :
   short_high_count_r;
// terminal at one
// A loaded value of zero or one ends the phase at the first tick, so a
// phase always lasts at least one tick.
assign tc_now = ctrl_r[`TMR_RUN_BIT] && loaded_r && tick &&
   (count_r <= 8'h01);

// Count down on each tick; output toggles at every terminal count.
// Stopping the timer keeps the count and the output level; the next start
// reloads from the hold that matches the level left behind.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      count_r <= `TMR_RST_BYTE;
      loaded_r <= 1'b0;
      tc_r <= 1'b0;
      o_eight_bit_timer_output <= 1'b0;
   end else begin
      tc_r <= tc_now;
      if (!ctrl_r[`TMR_RUN_BIT]) begin
         loaded_r <= 1'b0;
      end else if (!loaded_r) begin
         loaded_r <= 1'b1;
         count_r <= o_eight_bit_timer_output ? short_high_count_r :
            short_low_count_r;
      end else if (tc_now) begin
         count_r <= reload_val;
         o_eight_bit_timer_output <= !o_eight_bit_timer_output;
      end else if (tick) begin
         count_r <= count_r - 8'h01;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Outputs: pin routing, gated interrupts and long timer reload.
// With the route bit clear the pin follows the port value through the synchroniser, so a change
// on the port appears on the pin three clocks later.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      o_port3_pin4 <= 1'b0;
      o_timeout_irq <= 1'b0;
      o_capture_irq <= 1'b0;
      o_long_load <= 1'b0;
      o_long_reload <= `TMR_RST_WORD;
   end else begin
      o_port3_pin4 <= ctrl_r[`TMR_ROUTE_BIT] ? o_eight_bit_timer_output :
         port_s2_r;
      o_timeout_irq <= tc_r && ctrl_r[`TMR_TOMSK_BIT];
      o_capture_irq <= cap_s2_r && !cap_d_r && ctrl_r[`TMR_CAPMSK_BIT];
      o_long_load <= start_s2_r && !start_d_r;
      o_long_reload <= {long_reload_upper_r, long_reload_lower_r};
   end
end

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path; one read at a time.
// The address is decoded at the hand-over edge and the answer stands in
// the read data register until the master takes it.
always @(posedge i_clock) begin
   if (i_sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TMR_RESP_OK;
   end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TMR_RESP_OK;
         case (s_axi_araddr[9:2])
            `TMR_IDX_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
            `TMR_IDX_T8LO: s_axi_rdata <= {24'h000000, short_low_count_r};
            `TMR_IDX_T8HI: s_axi_rdata <= {24'h000000, short_high_count_r};
            `TMR_IDX_T16LO: s_axi_rdata <= {24'h000000, long_reload_lower_r};
            `TMR_IDX_T16HI: s_axi_rdata <= {24'h000000, long_reload_upper_r};
            `TMR_IDX_STAT: s_axi_rdata <= {24'h000000, count_r};
            `TMR_IDX_OUTS: s_axi_rdata <= {31'h00000000,
               o_eight_bit_timer_output};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `TMR_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
end
endmodule // tmr_timer_top

/* File: core/tmr_defs.vh */
// Register offsets, field positions and reset values of the timer block.
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
// Register indices; the bus byte address is four times the index.
`define TMR_IDX_CTRL 8'h00
`define TMR_IDX_T8LO 8'h04
`define TMR_IDX_T8HI 8'h05
`define TMR_IDX_T16LO 8'h06
`define TMR_IDX_T16HI 8'h07
`define TMR_IDX_STAT 8'h08
`define TMR_IDX_OUTS 8'h09
// Control field positions.
`define TMR_RUN_BIT 7
`define TMR_ONESHOT_BIT 6
`define TMR_TOUT_BIT 5
`define TMR_PRE_HI 4
`define TMR_PRE_LO 3
`define TMR_CAPMSK_BIT 2
`define TMR_TOMSK_BIT 1
`define TMR_ROUTE_BIT 0
// Reset values.
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_RST_PRE 3'h0
// AXI responses.
`define TMR_RESP_OK 2'h0
`define TMR_RESP_SLVERR 2'h2
`endif

/* File: core/tmr_prescaler.v */
// Clock prescaler producing a one-cycle tick at the selected divide ratio.
`timescale 1ns/100ps
module tmr_prescaler (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_run,
   input wire [1:0] i_sel,
   output reg o_tick
);
`include "tmr_defs.vh"
reg [2:0] div_r;
reg [2:0] mask;

// Divide mask: sysclk, /2, /4, /8.
always @* begin
   case (i_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      default: mask = 3'h7;
   endcase
end

// Free divider held in reset while stopped so the first tick is aligned.
always @(posedge i_clock) begin
   if (i_sys_rst || !i_run) begin
      div_r <= `TMR_RST_PRE;
      o_tick <= 1'b0;
   end else begin
      div_r <= div_r + 3'h1;
      o_tick <= ((div_r & mask) == mask);
   end
end
endmodule // tmr_prescaler

/* File: tb/tmr_timer_sva.sv */
// Port checker for the timer block.
`timescale 1ns/100ps
module tmr_timer_sva (
   input wire i_clock,
   input wire i_sys_rst,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire o_timeout_irq,
   input wire o_capture_irq,
   input wire o_long_load,
   input wire o_eight_bit_timer_output
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////
   // time-out follows a toggle of the timer output.
   a_tout_toggle: assert property (
      o_timeout_irq |-> $past(o_eight_bit_timer_output) !=
         $past(o_eight_bit_timer_output, 2))
      else $error("time-out without output toggle");
   a_cap_pulse: assert property (o_capture_irq |=> !o_capture_irq)
      else $error("capture pulse too long");
   a_load_pulse: assert property (o_long_load |=> !o_long_load)
      else $error("long load pulse too long");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_byte_data: assert property (
      s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_err_zero: assert property (
      s_axi_rvalid && s_axi_rresp != 2'h0 |->
         s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("bad error response");
   a_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_write_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while answering");
endmodule // tmr_timer_sva

/* File: tb/tb_top.sv */
// Self-checking bench for the timer block.
`timescale 1ns/100ps
module tb_top;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_smr = 1'b0, i_long_start = 1'b0, i_capture_event = 1'b0;
   logic i_port_data = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
   logic arv = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic awr, wr, bv, arr, rv, t_out, pin, tirq, cirq, lload;
   logic [1:0] bresp, rresp;
   logic [15:0] lrel;
   logic [33:0] expq[$];
   logic [1:0] bexp[$];
   logic [7:0] adr[5] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1C};
   int failures = 0, samples_checked = 0, cyc = 0;
   // Free-running 200 MHz clock.
   always #2.5 i_clock = ~i_clock;
   tmr_timer_top uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_smr(i_smr),
      .i_long_start(i_long_start), .i_capture_event(i_capture_event),
      .i_port_data(i_port_data), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
      .o_eight_bit_timer_output(t_out), .o_port3_pin4(pin),
      .o_timeout_irq(tirq), .o_capture_irq(cirq), .o_long_load(lload),
      .o_long_reload(lrel));
   ////////////////////////////////////////////////////////////////////////
   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Writes one register; each channel is released when taken.
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      bexp.push_back((a == 8'h00 || (a >= 8'h10 && a <= 8'h24)) ?
         2'h0 : 2'h2);
      awaddr <= {24'h0, a};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge i_clock);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bready && bv) bready <= 1'b0;
      end while (awv || wv || bready);
   endtask
   // Reads one register and notes the expected answer.
   task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      araddr <= {24'h0, a};
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge i_clock);
         if (arv && arr) arv <= 1'b0;
         if (rready && rv) rready <= 1'b0;
      end while (arv || rready);
   endtask
   task automatic rd8(input logic [7:0] a, input logic [7:0] b);
      rd_reg(a, {26'h0, b});
   endtask
   // Counts pulses of one output over a window of eight cycles.
   task automatic pulses(input int which, input int e);
      int s;
      s = 0;
      repeat (8) begin
         @(negedge i_clock);
         s += ((which == 0 ? lload : which == 1 ? cirq : tirq) === 1'b1);
      end
      chk(34'(s), 34'(e));
      @(posedge i_clock);
   endtask
   // Measures one whole phase of the timer output at level lv.
   task automatic phase(input logic lv, input int e);
      int c;
      c = 0;
      while (t_out === lv) @(negedge i_clock);
      while (t_out !== lv) @(negedge i_clock);
      while (t_out === lv) begin
         c++;
         @(negedge i_clock);
      end
      chk(34'(c), 34'(e));
      @(posedge i_clock);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Compares read answers in order and cuts a hang short.
   always @(posedge i_clock) begin
      if (rv === 1'b1 && rready === 1'b1)
         chk({rresp, rdata}, expq.pop_front());
      if (bv === 1'b1 && bready === 1'b1)
         chk({32'h0, bresp}, {32'h0, bexp.pop_front()});
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   // Main sequence.
   initial begin
      logic [7:0] v[5];
      void'($urandom(96));
      repeat (10) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      foreach (adr[i]) rd8(adr[i], 8'h00);
      for (int i = 1; i < 5; i++) begin
         v[i] = 8'($urandom);
         wr_reg(adr[i], {24'($urandom), v[i]});
         rd8(adr[i], v[i]);
      end
      chk({18'h0, lrel}, {18'h0, v[4], v[3]});
      i_long_start <= 1'b1;
      pulses(0, 1);
      i_long_start <= 1'b0;
      rd_reg(8'h40, {2'h2, 32'h0});
      wr_reg(8'h44, 32'hFF);
      wr_reg(8'h10, 32'h3);
      wr_reg(8'h14, 32'h2);
      wr_reg(8'h00, 32'h20);
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'h00, 32'(8'h82 | (s << 3)));
         phase(1'b1, 2 << s);
         phase(1'b0, 3 << s);
         wr_reg(8'h00, 32'h0);
      end
      rd8(8'h00, 8'h20);
      wr_reg(8'h00, 32'h20);
      rd8(8'h00, 8'h00);
      wr_reg(8'h00, 32'hC0);
      pulses(2, 0);
      rd8(8'h00, 8'h60);
      wr_reg(8'h00, 32'hC2);
      pulses(2, 1);
      wr_reg(8'h00, 32'h24);
      i_capture_event <= 1'b1;
      pulses(1, 1);
      i_capture_event <= 1'b0;
      wr_reg(8'h00, 32'h0);
      i_capture_event <= 1'b1;
      pulses(1, 0);
      for (int i = 0; i < 4; i++) begin
         i_port_data <= 1'($urandom);
         repeat (4) @(posedge i_clock);
         chk({33'h0, pin}, {33'h0, i_port_data});
      end
      wr_reg(8'h00, 32'h1);
      repeat (3) @(posedge i_clock);
      chk({33'h0, pin}, {33'h0, t_out});
      wr_reg(8'h00, 32'h5F);
      i_smr <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_smr <= 1'b0;
      repeat (4) @(posedge i_clock);
      rd8(8'h00, 8'h1E);
      rd8(8'h18, v[3]);
      report_and_stop();
   end
endmodule // tb_top
bind tmr_timer_top tmr_timer_sva chk_i (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .o_timeout_irq(o_timeout_irq), .o_capture_irq(o_capture_irq),
   .o_long_load(o_long_load),
   .o_eight_bit_timer_output(o_eight_bit_timer_output));
